// ==== nlf_consts.vh ====
// constants for the nonvolatile lock, fuse and configuration block
`ifndef NLF_CONSTS_VH
`define NLF_CONSTS_VH

// fuse word layout, high group bits 12..6, low group bits 5..0
`define NLF_FUSE_W        13
`define NLF_F_DEBUG       12
`define NLF_F_TESTPORT    11
`define NLF_F_SERIAL      10
`define NLF_F_EEPRES      9
`define NLF_F_BSZ_HI      8
`define NLF_F_BSZ_LO      7
`define NLF_F_BOOT_RESET_VECTOR_FUSE     6
`define NLF_F_BODLVL      5
`define NLF_F_BROWNOUT_ENABLE_FUSE       4
`define NLF_F_CK_HI       3
`define NLF_F_CK_LO       0
// defaults: debug 1, test port 0, serial 0, preserve 1, size 11, boot_reset_vector_fuse 1,
// level 1, bod enable 1, clock 0010
`define NLF_FUSE_RESET    13'h13f2

// lock word layout: boot_lock_hi, boot_lock_lo, lock2, memory_lock_first
`define NLF_LOCK_W        4
`define NLF_L_BOOT_HI     3
`define NLF_L_BOOT_LO     2
`define NLF_L_MEM2        1
`define NLF_L_MEM1        0
`define NLF_LOCK_RESET    4'hf

// action select codes
`define NLF_ACT_ADDR      2'h0
`define NLF_ACT_DATA      2'h1
`define NLF_ACT_CMD       2'h2
`define NLF_ACT_IDLE      2'h3

// command bytes
`define NLF_CMD_ERASE     8'h80
`define NLF_CMD_WFUSE     8'h40
`define NLF_CMD_WLOCK     8'h20
`define NLF_CMD_WFLASH    8'h10
`define NLF_CMD_WEEP      8'h11
`define NLF_CMD_RSIG      8'h08
`define NLF_CMD_RFUSE     8'h04

// signature addresses
`define NLF_SIG_ADDR0     8'h00
`define NLF_SIG_ADDR1     8'h01
`define NLF_SIG_ADDR2     8'h02

// timing
`define NLF_CLK_NS        20
`define NLF_PULSE_NS      500
`define NLF_PULSE_CYC     ((`NLF_PULSE_NS + `NLF_CLK_NS - 1) / `NLF_CLK_NS)
`define NLF_BUSY_CYC      8

`endif

// ==== nlf_lock_fuse.v ====
// nonvolatile lock and fuse decoder with parallel programming front end
// Behaviour
// - boot locks 1,1 leave store and load accesses to boot section free.
// - boot lock modes 2 and 3 block store writes into boot section.
// - modes 3 and 4 block boot-section loads issued from application code.
// - modes 3 and 4 with application vectors mask interrupts inside boot code.
// - thirteen fuses: seven high group bits and six low group bits.
// - all fuses reachable in parallel mode; serial skips serial-enable.
// - debug active only with debug fuse and test port fuse both programmed.
// - programmed debug fuse keeps clock parts running in every sleep mode.
// - programmed test port fuse routes test interface onto port c pins 5..2.
// - programmed serial-enable fuse allows serial program and data download.
// - programmed preserve fuse keeps eeprom contents through chip erase.
// - preserve fuse cannot be programmed while any lock bit is programmed.
// - two-bit boot size field picks boot section size and start address.
// - programmed boot reset fuse moves reset vector to boot start, else 0000.
// - brownout enable fuse turns detection on; level fuse selects level.
// - four-bit clock field selects clock source and start-up delay.
// - chip erase leaves every fuse value unchanged.
// - fuses locked once first memory lock bit programmed; fuses go first.
// - three signature bytes at 000..002 of a read-only space.
// - calibration byte sits in the high byte of signature address 000.
// - crystal pulse performs action select; strobes run last loaded command.
// - action 00 address, 01 data by byte select, 10 command, 11 idle.
// - command bytes decode erase, fuse, lock, flash, eeprom, signature, fuse read.
// - ready/busy output low while busy, high when ready.
`timescale 1ns/1ps
`default_nettype none
`include "nlf_consts.vh"

module nlf_lock_fuse #(
    parameter [7:0] SIG_BYTE0  = 8'h5a, // arbitrary identity value
    parameter [7:0] SIG_BYTE1  = 8'h3c, // arbitrary identity value
    parameter [7:0] SIG_BYTE2  = 8'h07, // arbitrary identity value
    parameter [7:0] CAL_BYTE   = 8'h80,
    parameter       BOOT_AW    = 14,
    parameter       BUSY_CYC   = `NLF_BUSY_CYC
) (
    // clock and reset
    input  wire                   clock,
    input  wire                   nrst,
    // programming mode and parallel programming pins
    input  wire                   prog_mode,
    input  wire                   crystal_in_pin,
    input  wire                   action_select_hi,
    input  wire                   action_select_lo,
    input  wire                   byte_select_one,
    input  wire                   write_strobe_n,
    input  wire                   output_enable_n,
    input  wire [7:0]             data_in,
    output reg  [7:0]             data_out,
    output wire                   data_oe_n,
    output wire                   ready_busy_out,
    // serial programming path to fuses
    input  wire                   serial_fuse_we,
    input  wire [`NLF_FUSE_W-1:0] serial_fuse_wdata,
    // core access checks
    input  wire                   exec_in_boot,
    input  wire                   vectors_in_boot,
    input  wire                   store_req,
    input  wire                   store_to_boot,
    input  wire                   load_req,
    input  wire                   load_from_boot,
    output wire                   store_allowed,
    output wire                   load_allowed,
    output wire                   irq_block,
    // decoded configuration
    output wire                   debug_active,
    output wire                   sleep_clock_keep,
    output wire                   test_port_on_pc,
    output wire                   serial_prog_enabled,
    output wire                   eeprom_erase_enable,
    output wire [1:0]             boot_size_sel,
    output reg  [BOOT_AW-1:0]     reset_vector,
    output wire                   brownout_enable,
    output wire                   brownout_level,
    output wire [3:0]             clock_source_sel,
    output wire [7:0]             oscillator_cal,
    // strobes toward flash and eeprom controllers
    output reg                    erase_pulse,
    output reg                    flash_write_pulse,
    output reg                    eeprom_write_pulse,
    output reg  [15:0]            prog_address,
    output reg  [15:0]            prog_data
);

    // cell flops stand in for the nonvolatile
    // array and return to erased values on reset;
    // a real array would keep its contents.
    // decoded outputs except eeprom_erase_enable use a copy taken at reset
    // release, so checks stay steady at run time.
    // pins are taken as synchronous to the clock.

    // ready takes loads and strobes, busy not
    localparam ST_READY = 1'b0;
    localparam ST_BUSY  = 1'b1;
    localparam [7:0] BUSY_LEN = BUSY_CYC;

    // nonvolatile cells, kept in flops here; erased by chip erase or reset (locks)
    // fuses change only by the two write paths and by reset
    reg [`NLF_FUSE_W-1:0] fuse_cells;
    reg [`NLF_LOCK_W-1:0] lock_cells;
    // running copies taken at reset release
    reg [`NLF_FUSE_W-1:0] fuse_cfg;
    reg [`NLF_LOCK_W-1:0] lock_cfg;
    reg                   cfg_loaded;
    // programming front end state
    reg [7:0]             command;
    reg                   state;
    reg [7:0]             busy_cnt;
    reg                   xtal_d;
    reg                   wr_d;

    // boot section start for a given size code, in words
    // a smaller size code gives a larger section
    function [BOOT_AW-1:0] boot_start;
        input [1:0] size;
        begin
            case (size)
                2'h0:    boot_start = {BOOT_AW{1'b1}} << 11;
                2'h1:    boot_start = {BOOT_AW{1'b1}} << 10;
                2'h2:    boot_start = {BOOT_AW{1'b1}} << 9;
                default: boot_start = {BOOT_AW{1'b1}} << 8;
            endcase
        end
    endfunction

    // crystal rise loads, write fall executes
    wire       xtal_rise = crystal_in_pin & ~xtal_d;
    wire       wr_fall   = ~write_strobe_n & wr_d;
    wire [1:0] action    = {action_select_hi, action_select_lo};
    // any programmed lock guards the preserve fuse
    wire       any_lock  = ~&lock_cells;
    // fuses frozen once the first memory lock bit is programmed
    wire       fuse_lock = ~lock_cells[`NLF_L_MEM1];

    // read commands, shared by data and enable
    wire       cmd_rsig  = (command == `NLF_CMD_RSIG);
    wire       cmd_rfuse = (command == `NLF_CMD_RFUSE);
    wire       cmd_read  = cmd_rsig | cmd_rfuse;

    // next fuse value: preserve bit may not go to 0 while any lock is programmed
    // shared by the parallel and serial paths
    function [`NLF_FUSE_W-1:0] fuse_filter;
        input [`NLF_FUSE_W-1:0] req;
        input [`NLF_FUSE_W-1:0] cur;
        input                   locked;
        begin
            fuse_filter = req;
            if (locked && !req[`NLF_F_EEPRES])
                fuse_filter[`NLF_F_EEPRES] = cur[`NLF_F_EEPRES];
        end
    endfunction

    // edge detectors on the programming strobes
    // reset values equal the idle pin levels,
    // so no false edge follows reset;
    // each edge acts once however long the pulse
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            xtal_d <= 1'b0;
            wr_d   <= 1'b1;
        end else begin
            xtal_d <= crystal_in_pin;
            wr_d   <= write_strobe_n;
        end
    end

    // parallel programming loader and command execution
    // edges that come while busy are dropped,
    // not queued: the programmer must wait for
    // ready before the next write pulse;
    // pulse widths are the programmer's duty
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            command            <= 8'h00;
            prog_address       <= 16'h0000;
            prog_data          <= 16'h0000;
            state              <= ST_READY;
            busy_cnt           <= 8'h00;
            erase_pulse        <= 1'b0;
            flash_write_pulse  <= 1'b0;
            eeprom_write_pulse <= 1'b0;
            // cells back to erased values (flop limit)
            fuse_cells         <= `NLF_FUSE_RESET;
            lock_cells         <= `NLF_LOCK_RESET;
        end else begin
            // memory strobes last one cycle
            erase_pulse        <= 1'b0;
            flash_write_pulse  <= 1'b0;
            eeprom_write_pulse <= 1'b0;
            case (state)
                ST_READY: begin
                    // pulses are assumed long enough; edges are taken each once
                    if (prog_mode && xtal_rise) begin
                        // action select picks the target register
                        if (action == `NLF_ACT_ADDR) begin
                            if (byte_select_one)
                                prog_address[15:8] <= data_in;
                            else
                                prog_address[7:0] <= data_in;
                        end else if (action == `NLF_ACT_DATA) begin
                            if (byte_select_one)
                                prog_data[15:8] <= data_in;
                            else
                                prog_data[7:0] <= data_in;
                        end else if (action == `NLF_ACT_CMD) begin
                            command <= data_in;
                        end
                    end else if (prog_mode && wr_fall) begin
                        state    <= ST_BUSY;
                        busy_cnt <= BUSY_LEN;
                        if (command == `NLF_CMD_ERASE) begin
                            // chip erase clears locks, fuses untouched
                            lock_cells  <= `NLF_LOCK_RESET;
                            erase_pulse <= 1'b1;
                        end else if (command == `NLF_CMD_WFUSE) begin
                            // frozen fuses drop the write, still busy
                            if (!fuse_lock)
                                fuse_cells <= fuse_filter({prog_data[14:8], prog_data[5:0]},
                                                          fuse_cells, any_lock);
                        end else if (command == `NLF_CMD_WLOCK) begin
                            // lock bits only move toward programmed
                            // only chip erase or reset returns them to 1
                            lock_cells <= lock_cells & {prog_data[5:4], prog_data[2:1]};
                        end else if (command == `NLF_CMD_WFLASH) begin
                            flash_write_pulse <= 1'b1;
                        end else if (command == `NLF_CMD_WEEP) begin
                            eeprom_write_pulse <= 1'b1;
                        end else begin
                            // reads need no busy time
                            state <= ST_READY;
                        end
                    end else if (serial_fuse_we && !fuse_lock) begin
                        // taken only while the parallel side idles
                        // serial path cannot change the serial-enable fuse
                        fuse_cells <= fuse_filter(
                            {serial_fuse_wdata[`NLF_FUSE_W-1:`NLF_F_SERIAL+1],
                             fuse_cells[`NLF_F_SERIAL],
                             serial_fuse_wdata[`NLF_F_SERIAL-1:0]},
                            fuse_cells, any_lock);
                    end
                end
                default: begin
                    // fixed busy time, then ready again
                    if (busy_cnt == 8'h01)
                        state <= ST_READY;
                    busy_cnt <= busy_cnt - 8'h01;
                end
            endcase
        end
    end

    // ready straight from the state flop
    assign ready_busy_out = (state == ST_READY);

    // read path: signature, calibration, fuses and locks
    // pins driven only under a read command, so
    // an early output enable cannot fight the bus
    assign data_oe_n = ~(prog_mode & ~output_enable_n & cmd_read);

    // data follows command, address and byte
    // select one cycle late
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            data_out <= 8'h00;
        end else if (cmd_rsig) begin
            if (prog_address[7:0] == `NLF_SIG_ADDR0)
                data_out <= byte_select_one ? CAL_BYTE : SIG_BYTE0;
            else if (prog_address[7:0] == `NLF_SIG_ADDR1)
                data_out <= SIG_BYTE1;
            else if (prog_address[7:0] == `NLF_SIG_ADDR2)
                data_out <= SIG_BYTE2;
            else
                data_out <= 8'h00;
        end else if (cmd_rfuse) begin
            // unused bits read as 1
            if (byte_select_one)
                data_out <= {1'b1, fuse_cells[12:6]};
            else
                data_out <= {2'h3, fuse_cells[5:0]};
        end else begin
            // lock byte for any other command
            data_out <= {2'h3, lock_cells[3:2], 1'b1, lock_cells[1:0], 1'b1};
        end
    end

    // capture configuration one cycle after reset release
    // taken once: cell writes wait for the next
    // reset, so the reset vector cannot move
    // and decoding, save eeprom_erase_enable, cannot change under running code
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            // defaults until the first edge after release
            fuse_cfg   <= `NLF_FUSE_RESET;
            lock_cfg   <= `NLF_LOCK_RESET;
            cfg_loaded <= 1'b0;
            reset_vector <= {BOOT_AW{1'b0}};
        end else if (!cfg_loaded) begin
            fuse_cfg   <= fuse_cells;
            lock_cfg   <= lock_cells;
            cfg_loaded <= 1'b1;
            // boot reset fuse programmed points at boot start
            reset_vector <= fuse_cells[`NLF_F_BOOT_RESET_VECTOR_FUSE] ? {BOOT_AW{1'b0}} :
                            boot_start(fuse_cells[`NLF_F_BSZ_HI:`NLF_F_BSZ_LO]);
        end
    end

    // boot lock modes; 0 = programmed
    // mode 2 guards stores, mode 4 loads, mode 3
    // both, so each guard follows one lock bit
    wire bl_hi     = lock_cfg[`NLF_L_BOOT_HI];
    wire bl_lo     = lock_cfg[`NLF_L_BOOT_LO];
    wire no_store  = ~bl_lo;
    wire no_load   = ~bl_hi;

    // mode 1 leaves everything free since both guards are low
    // boot code may always load its own section;
    // interrupts stay on while boot owns vectors
    assign store_allowed = ~(store_req & store_to_boot & no_store);
    assign load_allowed  = ~(load_req & load_from_boot & ~exec_in_boot & no_load);
    assign irq_block     = no_load & ~vectors_in_boot & exec_in_boot;

    // decoded fuse outputs, all active high meaning feature on
    // a programmed fuse reads 0, hence the inverts;
    // debug needs both fuses, sleep clocks only one
    assign debug_active        = ~fuse_cfg[`NLF_F_DEBUG] & ~fuse_cfg[`NLF_F_TESTPORT];
    assign sleep_clock_keep    = ~fuse_cfg[`NLF_F_DEBUG];
    assign test_port_on_pc     = ~fuse_cfg[`NLF_F_TESTPORT];
    assign serial_prog_enabled = ~fuse_cfg[`NLF_F_SERIAL];
    // live cell so a freshly written preserve fuse counts at the next erase
    assign eeprom_erase_enable = fuse_cells[`NLF_F_EEPRES];
    assign boot_size_sel       = fuse_cfg[`NLF_F_BSZ_HI:`NLF_F_BSZ_LO];
    // level passes through to the detector
    assign brownout_enable     = ~fuse_cfg[`NLF_F_BROWNOUT_ENABLE_FUSE];
    assign brownout_level      = fuse_cfg[`NLF_F_BODLVL];
    assign clock_source_sel    = fuse_cfg[`NLF_F_CK_HI:`NLF_F_CK_LO];
    // fixed calibration byte, as in signature read
    assign oscillator_cal      = CAL_BYTE;

endmodule
`default_nettype wire

// ==== nlf_lock_fuse_monitor.sv ====
// assertion checker watching the lock, fuse and configuration ports
`timescale 1ns/1ps
`default_nettype none
module nlf_lock_fuse_chk #(
    parameter BUSY_CYC = 8
) (
    // clock and reset
    input wire logic       clock,
    input wire logic       nrst,
    // handshake and strobes
    input wire logic       ready_busy_out,
    input wire logic       erase_pulse,
    input wire logic       flash_write_pulse,
    input wire logic       eeprom_write_pulse,
    // core access checks
    input wire logic       store_req,
    input wire logic       store_allowed,
    input wire logic       load_req,
    input wire logic       load_allowed,
    input wire logic       irq_block,
    // decoded configuration
    input wire logic       debug_active,
    input wire logic [1:0] boot_size_sel,
    input wire logic [3:0] clock_source_sel
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    int  busy_cnt;
    wire any_pulse = erase_pulse | flash_write_pulse | eeprom_write_pulse;
    // busy length counter, a repetition cannot take the parameter directly
    always @(posedge clock or negedge nrst) begin
        if (!nrst)
            busy_cnt <= 0;
        else if (!ready_busy_out)
            busy_cnt <= busy_cnt + 1;
        else
            busy_cnt <= 0;
    end
    busy_len_a: assert property ($rose(ready_busy_out) |-> busy_cnt == BUSY_CYC)
        else $error("busy length wrong");
    pulse_start_a: assert property (any_pulse |-> $fell(ready_busy_out))
        else $error("strobe outside busy start");
    pulse_single_a: assert property ($onehot0({erase_pulse, flash_write_pulse, eeprom_write_pulse}))
        else $error("two strobes at once");
    pulse_short_a: assert property (any_pulse |=> !any_pulse ##1 !any_pulse)
        else $error("strobe too long");
    store_free_a: assert property (store_req |-> store_allowed)
        else $error("store blocked in open mode");
    load_free_a: assert property (load_req |-> load_allowed)
        else $error("load blocked in open mode");
    irq_free_a: assert property (!irq_block)
        else $error("interrupts blocked in open mode");
    cfg_dflt_a: assert property (boot_size_sel == 2'h3 && clock_source_sel == 4'h2)
        else $error("config differs from defaults");
    debug_off_a: assert property (!debug_active)
        else $error("debug on with default fuses");
endmodule
bind nlf_lock_fuse nlf_lock_fuse_chk #(.BUSY_CYC(BUSY_CYC)) u_chk (
    .clock(clock), .nrst(nrst), .ready_busy_out(ready_busy_out),
    .erase_pulse(erase_pulse), .flash_write_pulse(flash_write_pulse),
    .eeprom_write_pulse(eeprom_write_pulse), .store_req(store_req),
    .store_allowed(store_allowed), .load_req(load_req), .load_allowed(load_allowed),
    .irq_block(irq_block), .debug_active(debug_active),
    .boot_size_sel(boot_size_sel), .clock_source_sel(clock_source_sel));
`default_nettype wire

// ==== nlf_prog_model.sv ====
// parallel programmer model driving the programming pins
`timescale 1ns/1ps
`default_nettype none
module nlf_prog_model (
    // clock and device answers
    input wire logic       clock,
    input wire logic       ready_busy_out,
    input wire logic [7:0] data_out,
    input wire logic       data_oe_n,
    // programming pins
    output logic           crystal_in_pin,
    output logic [1:0]     action_sel,
    output logic           byte_select_one,
    output logic           write_strobe_n,
    output logic           output_enable_n,
    output logic [7:0]     data_in
);
    int hold = 25; // pulse width in cycles, 500 ns at 20 ns
    initial begin
        crystal_in_pin = 1'b0;
        action_sel = 2'h3;
        byte_select_one = 1'b0;
        write_strobe_n = 1'b1;
        output_enable_n = 1'b1;
        data_in = 8'h00;
    end
    // one crystal pulse performs the selected action
    task automatic load(input logic [1:0] a, input logic bs, input logic [7:0] d);
        @(negedge clock);
        action_sel = a;
        byte_select_one = bs;
        data_in = d;
        repeat (2) @(negedge clock);
        crystal_in_pin = 1'b1;
        repeat (hold) @(negedge clock);
        crystal_in_pin = 1'b0;
        repeat (2) @(negedge clock);
        action_sel = 2'h3;
        data_in = ~d; // released bus must not keep the old byte
    endtask
    // write pulse runs the last command, then wait for ready
    task automatic strobe(output bit ok);
        int n;
        @(negedge clock);
        write_strobe_n = 1'b0;
        repeat (hold) @(negedge clock);
        write_strobe_n = 1'b1;
        n = 0;
        while (ready_busy_out !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        ok = (ready_busy_out === 1'b1);
    endtask
    // output enable read of the selected byte
    task automatic rd(input logic bs, output logic [7:0] q, output logic oen);
        @(negedge clock);
        byte_select_one = bs;
        output_enable_n = 1'b0;
        repeat (3) @(negedge clock);
        q = data_out;
        oen = data_oe_n;
        output_enable_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== tb_nlf_lock_fuse.sv ====
// self-checking bench for the lock, fuse and configuration block
`timescale 1ns/1ps
`default_nettype none
`include "nlf_consts.vh"
module tb_nlf_lock_fuse;
    localparam logic [7:0] SIG0 = 8'h21; // arbitrary identity value
    localparam logic [7:0] SIG1 = 8'h43; // arbitrary identity value
    localparam logic [7:0] SIG2 = 8'h65; // arbitrary identity value
    localparam logic [7:0] CAL  = 8'h9c;
    logic clock, nrst, prog_mode, xtal, bs1, wr_n, oe_n, oe_drv_n, rdy, sfw;
    logic [1:0] act;
    logic [7:0] din, dout, q, oc, sig_tab [4], cmds [3];
    logic [12:0] sfd, f;
    logic eib, vib, sreq, stb, lreq, lfb, st_ok, ld_ok, irqb, oen;
    logic dbg, slk, tpo, spe, eee, boe, bol, erp, flp, eep;
    logic [1:0] bsz;
    logic [3:0] cks;
    logic [13:0] rvec;
    logic [15:0] pa, pd;
    logic [2:0] seen, e;
    int fails = 0;
    int n_checks = 0;
    nlf_lock_fuse #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2), .CAL_BYTE(CAL)) u_dut (
        .clock(clock), .nrst(nrst), .prog_mode(prog_mode), .crystal_in_pin(xtal),
        .action_select_hi(act[1]), .action_select_lo(act[0]), .byte_select_one(bs1),
        .write_strobe_n(wr_n), .output_enable_n(oe_n), .data_in(din), .data_out(dout),
        .data_oe_n(oe_drv_n), .ready_busy_out(rdy), .serial_fuse_we(sfw),
        .serial_fuse_wdata(sfd), .exec_in_boot(eib), .vectors_in_boot(vib),
        .store_req(sreq), .store_to_boot(stb), .load_req(lreq), .load_from_boot(lfb),
        .store_allowed(st_ok), .load_allowed(ld_ok), .irq_block(irqb), .debug_active(dbg),
        .sleep_clock_keep(slk), .test_port_on_pc(tpo), .serial_prog_enabled(spe),
        .eeprom_erase_enable(eee), .boot_size_sel(bsz), .reset_vector(rvec),
        .brownout_enable(boe), .brownout_level(bol), .clock_source_sel(cks),
        .oscillator_cal(oc), .erase_pulse(erp), .flash_write_pulse(flp),
        .eeprom_write_pulse(eep), .prog_address(pa), .prog_data(pd));
    nlf_prog_model u_prog (
        .clock(clock), .ready_busy_out(rdy), .data_out(dout), .data_oe_n(oe_drv_n),
        .crystal_in_pin(xtal), .action_sel(act), .byte_select_one(bs1),
        .write_strobe_n(wr_n), .output_enable_n(oe_n), .data_in(din));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // strobes seen since the last write pulse
    always @(posedge clock) seen <= seen | {erp, flp, eep};
    task automatic stop_test();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic do_reset();
        nrst = 1'b0;
        repeat (16) @(negedge clock);
        nrst = 1'b1;
        repeat (2) @(negedge clock);
    endtask
    // fuse word into the write-fuses data layout
    function automatic logic [15:0] fw(input logic [12:0] v);
        fw = {1'b1, v[12:6], 2'b11, v[5:0]};
    endfunction
    // expected {store ok, load ok, irq block} for boot lock bits m
    function automatic logic [2:0] exp_acc(input logic [1:0] m, input logic ex, vb, sb, lb);
        exp_acc[2] = !(sb && !m[0]);
        exp_acc[1] = !(lb && !ex && !m[1]);
        exp_acc[0] = !m[1] && !vb && ex;
    endfunction
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        bit ok;
        u_prog.load(`NLF_ACT_CMD, 1'b0, c);
        u_prog.load(`NLF_ACT_DATA, 1'b0, d[7:0]);
        u_prog.load(`NLF_ACT_DATA, 1'b1, d[15:8]);
        seen = 3'b000;
        u_prog.strobe(ok);
        if (!ok) begin
            fails++;
            stop_test();
        end
    endtask
    initial begin
        {nrst, prog_mode, sfw, eib, vib, sreq, stb, lreq, lfb} = 9'h080;
        sfd = `NLF_FUSE_RESET;
        sig_tab = '{SIG0, CAL, SIG1, SIG2};
        cmds = '{`NLF_CMD_ERASE, `NLF_CMD_WFLASH, `NLF_CMD_WEEP};
        void'($urandom(31249));
        do_reset();
        chk(16'({dbg, slk}), 16'h0);
        chk(16'({tpo, spe, eee, boe}), 16'he);
        chk(16'({bsz, cks}), 16'h32);
        chk(16'(rvec), 16'h0);
        chk(16'({bol, oc}), {8'h1, CAL});
        chk(16'(rdy), 16'h1);
        // random core traffic against the open boot lock mode
        repeat (100) begin
            @(negedge clock);
            {eib, vib, sreq, stb, lreq, lfb} = 6'($urandom);
            #1;
            e = exp_acc(2'b11, eib, vib, sreq && stb, lreq && lfb);
            chk(16'({st_ok | ~sreq, ld_ok | ~lreq, irqb}), 16'(e));
        end
        // signature bytes and calibration byte, all addresses
        for (int i = 0; i < 4; i++) begin
            u_prog.load(`NLF_ACT_CMD, 1'b0, `NLF_CMD_RSIG);
            u_prog.load(`NLF_ACT_ADDR, 1'b0, 8'(i < 2 ? 0 : i - 1));
            u_prog.rd(i == 1, q, oen);
            chk({8'h0, q}, {8'h0, sig_tab[i]});
            chk(16'(oen), 16'h0);
            chk(pa, 16'(i < 2 ? 0 : i - 1));
        end
        // random fuse words, then erase and memory strobes keep the preserve fuse
        repeat (3) begin
            f = 13'($urandom);
            wr(`NLF_CMD_WFUSE, fw(f));
            chk(pd, fw(f));
            chk(16'({seen, eee}), 16'({3'b000, f[`NLF_F_EEPRES]}));
        end
        for (int i = 0; i < 3; i++) begin
            wr(cmds[i], 16'($urandom));
            chk(16'({seen, eee}), 16'({3'b100 >> i, f[`NLF_F_EEPRES]}));
        end
        // serial path may program the preserve fuse
        do_reset();
        @(negedge clock);
        sfd = `NLF_FUSE_RESET & ~(13'h1 << `NLF_F_EEPRES);
        sfw = 1'b1;
        @(negedge clock);
        sfw = 1'b0;
        repeat (2) @(negedge clock);
        chk(16'(eee), 16'h0);
        // a programmed boot lock or first memory lock refuses the preserve fuse; slow programmer here
        u_prog.hold = 40;
        for (int i = 0; i < 2; i++) begin
            do_reset();
            wr(`NLF_CMD_WLOCK, i == 0 ? 16'h00ef : 16'h00fd);
            wr(`NLF_CMD_WFUSE, fw(`NLF_FUSE_RESET & ~(13'h1 << `NLF_F_EEPRES)));
            chk(16'(eee), 16'h1);
        end
        stop_test();
    end
endmodule
`default_nettype wire
